// File: bench/rdc_far_side.sv
// far-side model holding active and forwarding state of banked interrupts
`timescale 1ns/1ps
module rdc_far_side (
    input logic clk,
    input logic rst_b,
    input logic [31:0] set_act,
    input logic [31:0] set_fwd,
    input logic [31:0] deact,
    input logic [31:0] dis_fwd,
    output logic [31:0] act_reg,
    output logic [31:0] fwd_reg
);
    // state raised by the bench, removed by the block's one-cycle pulses
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            act_reg <= 32'h0;
            fwd_reg <= 32'h0;
        end else begin
            act_reg <= (act_reg | set_act) & ~deact;
            fwd_reg <= (fwd_reg | set_fwd) & ~dis_fwd;
        end
    end
endmodule

// File: bench/rdc_redist_ctrl_asserts.sv
// port-level checks of the redistributor control block
`timescale 1ns/1ps
module rdc_redist_ctrl_asserts (
    input logic CORE_CLK,
    input logic RST_B,
    input logic REG_SEL,
    input logic REG_WR,
    input logic [15:0] REG_ADDR,
    input logic [31:0] REG_WDATA,
    input logic REG_SECURE,
    input logic [31:0] REG_RDATA,
    input logic SINGLE_SECURITY_STATE,
    input logic NONSECURE_AFFINITY_ROUTING_EN,
    input logic PROCESSOR_ASLEEP,
    input logic GRP1NS_EN,
    input logic UPSTREAM_BUSY,
    input logic [31:0] IRQ_GROUP_SECURE,
    input logic [31:0] IRQ_ACTIVE,
    input logic [31:0] IRQ_FWD_EN,
    input logic SELECTABLE_G0,
    input logic SELECTABLE_G1NS,
    input logic [31:0] DEACTIVATE,
    input logic [31:0] DISABLE_FWD,
    input logic MSG_INTERRUPT_ENABLE,
    input logic PENDING_LOAD_START
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    // control write strobe and any-pulse flag
    wire wr_ctl = REG_SEL && REG_WR && REG_ADDR == 16'h0000;
    wire pulses = |(DEACTIVATE | DISABLE_FWD);
    property p_load;
        wr_ctl && REG_WDATA[0] && !MSG_INTERRUPT_ENABLE && NONSECURE_AFFINITY_ROUTING_EN
            |=> PENDING_LOAD_START;
    endproperty
    a_load: assert property (p_load) else $error("enable set without table load");
    property p_pulse;
        PENDING_LOAD_START |=> !PENDING_LOAD_START;
    endproperty
    a_pulse: assert property (p_pulse) else $error("table load pulse too long");
    property p_deact;
        |DEACTIVATE |-> $past(REG_SEL && REG_WR && REG_ADDR == 16'h0380)
            && (DEACTIVATE & ~$past(REG_WDATA & IRQ_ACTIVE)) == 32'h0;
    endproperty
    a_deact: assert property (p_deact) else $error("stray deactivate");
    property p_disfwd;
        |DISABLE_FWD |-> $past(REG_SEL && REG_WR && REG_ADDR == 16'h0180)
            && (DISABLE_FWD & ~$past(REG_WDATA & IRQ_FWD_EN)) == 32'h0;
    endproperty
    a_disfwd: assert property (p_disfwd) else $error("stray forward disable");
    property p_nssec;
        pulses && !$past(REG_SECURE) && !$past(SINGLE_SECURITY_STATE)
            |-> ((DEACTIVATE | DISABLE_FWD) & $past(IRQ_GROUP_SECURE)) == 32'h0;
    endproperty
    a_nssec: assert property (p_nssec) else $error("secure bit cleared by non-secure");
    property p_dis_g0;
        wr_ctl && REG_SECURE && REG_WDATA[24] |=> !SELECTABLE_G0;
    endproperty
    a_dis_g0: assert property (p_dis_g0) else $error("group 0 still selectable");
    property p_sel;
        SELECTABLE_G1NS |-> !PROCESSOR_ASLEEP && GRP1NS_EN;
    endproperty
    a_sel: assert property (p_sel) else $error("selectable while asleep or off");
    property p_rwp;
        REG_SEL && REG_WR && REG_ADDR == 16'h0180 ##2 REG_SEL && !REG_WR && REG_ADDR == 16'h0000
            |=> REG_RDATA[3];
    endproperty
    a_rwp: assert property (p_rwp) else $error("write pending flag low");
    property p_uwp;
        REG_SEL && !REG_WR && REG_ADDR == 16'h0000 |=> REG_RDATA[31] == $past(UPSTREAM_BUSY);
    endproperty
    a_uwp: assert property (p_uwp) else $error("upstream pending flag wrong");
endmodule
bind rdc_redist_ctrl rdc_redist_ctrl_asserts rdc_redist_ctrl_asserts_i (
    .CORE_CLK, .RST_B, .REG_SEL, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_SECURE, .REG_RDATA,
    .SINGLE_SECURITY_STATE, .NONSECURE_AFFINITY_ROUTING_EN, .PROCESSOR_ASLEEP, .GRP1NS_EN,
    .UPSTREAM_BUSY, .IRQ_GROUP_SECURE, .IRQ_ACTIVE, .IRQ_FWD_EN, .SELECTABLE_G0,
    .SELECTABLE_G1NS, .DEACTIVATE, .DISABLE_FWD, .MSG_INTERRUPT_ENABLE, .PENDING_LOAD_START
);

// File: bench/redistributor_control_and_clear_regs_tb.sv
// self-checking bench of the redistributor control block
`timescale 1ns/1ps
module redistributor_control_and_clear_regs_tb;
    typedef struct {logic [31:0] d; logic ws; logic rs; logic [31:0] e;} rdc_row_t;
    logic clk = 0, rst_b = 0, sel = 0, wr = 0, sec = 0, single = 0, rns = 1, rs = 1;
    logic asleep = 0, busy = 0, g0 = 1, g1s = 1, g1ns = 1, fx = 0, fw = 0;
    logic [15:0] addr = 16'h0;
    logic [31:0] wd = 32'h0, grp = 32'h0000_ffff, sa = 32'h0, sf = 32'h0;
    logic [31:0] rd, act, fwd, dact, dfwd;
    logic s0, s1s, s1ns, men, pls, rt;
    int n_errors = 0, n_checks = 0, cyc = 0;
    rdc_row_t rows [4] = '{'{32'h0700_0000, 1, 1, 32'h0700_0000}, '{0, 0, 1, 32'h0500_0000},
        '{32'h0700_0001, 0, 0, 32'h0200_0001}, '{0, 1, 1, 0}};
    // clock
    initial forever #5 clk = ~clk;
    rdc_redist_ctrl #(.PROP_CYCLES(4)) rdc_redist_ctrl_i (
        .CORE_CLK(clk), .RST_B(rst_b), .REG_SEL(sel), .REG_WR(wr), .REG_ADDR(addr),
        .REG_WDATA(wd), .REG_SECURE(sec), .REG_RDATA(rd), .SINGLE_SECURITY_STATE(single),
        .NONSECURE_AFFINITY_ROUTING_EN(rns), .SECURE_AFFINITY_ROUTING_EN(rs),
        .WAKE_ON_NONSECURE_GROUP1(fx), .PROCESSOR_ASLEEP(asleep), .GRP0_EN(g0),
        .GRP1S_EN(g1s), .GRP1NS_EN(g1ns), .UPSTREAM_BUSY(busy), .IRQ_GROUP_SECURE(grp),
        .IRQ_ACTIVE(act), .IRQ_FWD_EN(fwd), .FWD_G0(fw), .FWD_G1S(fw), .FWD_G1NS(fw),
        .SELECTABLE_G0(s0), .SELECTABLE_G1S(s1s), .SELECTABLE_G1NS(s1ns), .RETARGET_REQ(rt),
        .DEACTIVATE(dact), .DISABLE_FWD(dfwd), .MSG_INTERRUPT_ENABLE(men),
        .PENDING_LOAD_START(pls));
    rdc_far_side rdc_far_side_i (.clk(clk), .rst_b(rst_b), .set_act(sa), .set_fwd(sf),
        .deact(dact), .dis_fwd(dfwd), .act_reg(act), .fwd_reg(fwd));
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
            n_errors++;
        if (got !== exp)
            $display("[ERR] %0t expected %h got %h", $time, exp, got);
    endtask
    // one register access, request held up to its sampling edge
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic s);
        @(posedge clk);
        #1;
        sel = 1;
        wr = w;
        addr = a;
        wd = d;
        sec = s;
        @(posedge clk);
        #1;
        sel = 0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic s, input logic [31:0] exp);
        acc(0, a, 32'h0, s);
        @(posedge clk);
        #1;
        chk(exp, rd);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1;
        rdchk(16'h0000, 1, 32'h0);
        foreach (rows[i]) begin
            acc(1, 16'h0000, rows[i].d, rows[i].ws);
            repeat (8) @(posedge clk);
            rdchk(16'h0000, rows[i].rs, rows[i].e);
        end
        chk(32'h7, {29'h0, s0, s1s, s1ns});
        acc(1, 16'h0000, 32'h0100_0000, 1);
        chk(32'h3, {29'h0, s0, s1s, s1ns});
        g0 = 0;
        g1ns = 0;
        asleep = 1;
        #1;
        chk(32'h0, {29'h0, s0, s1s, s1ns});
        g0 = 1;
        g1ns = 1;
        asleep = 0;
        single = 1;
        acc(1, 16'h0000, 32'h0500_0000, 1);
        repeat (8) @(posedge clk);
        rdchk(16'h0000, 1, 32'h0100_0000);
        single = 0;
        sa = 32'hffff_ffff;
        sf = 32'hffff_ffff;
        @(posedge clk);
        #1;
        sa = 32'h0;
        sf = 32'h0;
        acc(1, 16'h0380, 32'h00ff_00ff, 0);
        rdchk(16'h0380, 1, 32'hff00_ffff);
        rdchk(16'h0380, 0, 32'hff00_0000);
        acc(1, 16'h0180, 32'h00ff_00ff, 1);
        rdchk(16'h0000, 1, 32'h0100_0008);
        repeat (8) @(posedge clk);
        rdchk(16'h0180, 1, 32'hff00_ff00);
        rdchk(16'h0000, 1, 32'h0100_0000);
        rs = 0;
        rdchk(16'h0380, 1, 32'hff00_0000);
        rs = 1;
        rdchk(16'h0004, 1, 32'h0);
        busy = 1;
        rdchk(16'h0000, 1, 32'h8100_0000);
        busy = 0;
        acc(1, 16'h0000, 32'h0000_0001, 1);
        chk(32'h1, {31'h0, men});
        chk(32'h1, {31'h0, pls});
        rns = 0;
        @(posedge clk);
        #1;
        rns = 1;
        #1;
        chk(32'h0, {31'h0, men});
        fw = 1;
        acc(1, 16'h0000, 32'h0100_0001, 1);
        chk(32'h1, {31'h0, rt});
        acc(1, 16'h0000, 32'h0100_0001, 1);
        chk(32'h0, {31'h0, rt});
        fw = 0;
        acc(1, 16'h0000, 32'h0100_0000, 1);
        rdchk(16'h0000, 1, 32'h0100_0008);
        repeat (8) @(posedge clk);
        acc(1, 16'h0000, 32'h0700_0001, 1);
        rst_b = 0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1;
        rdchk(16'h0000, 1, 32'h0);
        results();
    end
endmodule

// File: verilog/rdc_defines.vh
// register offsets, field positions and timing counts of the redistributor control block
`ifndef RDC_DEFINES_VH
`define RDC_DEFINES_VH
`define RDC_OFF_CONTROL 16'h0000
`define RDC_OFF_CLEAR_ACTIVE 16'h0380
`define RDC_OFF_CLEAR_ENABLE 16'h0180
`define RDC_BIT_UWP 31
`define RDC_BIT_DIS_G1S 26
`define RDC_BIT_DIS_G1NS 25
`define RDC_BIT_DIS_G0 24
`define RDC_BIT_RWP 3
`define RDC_BIT_MSG_EN 0
`define RDC_CTRL_RESET 1'b0
`define RDC_SGI_BITS 16
`define RDC_PROP_CYCLES 4
`endif

// File: verilog/rdc_redist_ctrl.v
// redistributor control, clear-active and clear-enable register logic
// Function
// - bit 31 reads 1 until all upstream writes reached the distributor
// - bit 26 set blocks secure group-1 one-of-N selection of this processor
// - bit 25 set blocks non-secure group-1 one-of-N selection
// - bit 24 set blocks group-0 one-of-N selection
// - without group-disable support the three disable bits read zero, ignore writes
// - secure group-1 disable bit: RAZ/WI if single state or non-secure access
// - group-0 disable bit: RAZ/WI to non-secure access with two states
// - disable bits and interrupt enable reset to zero
// - bit 3 reads 1 while disable, clear-enable or enable-clear writes propagate
// - bit 0 clear discards doorbells and ignores translation requests
// - enable bit reads zero without message support or non-secure routing
// - enable 0 to 1 write starts a pending-table load
// - enable may lock once set, chosen by a parameter
// - enable cleared or kept when non-secure routing drops, by parameter
// - selectable only awake, not disabled, group enabled; asleep never selectable, whatever the wake option
// - disable-bit change on forwarded interrupt requests a retarget
// - bits 15:0 software-generated, bits 31:16 private interrupts
// - clear-active reads active state, writing 1 deactivates active interrupts
// - clear bits RAZ/WI when routing disabled for the interrupt's security state
// - secure interrupt clear bits RAZ/WI to non-secure accesses with two states
// - clear-enable reads forwarding enable, writing 1 disables forwarding
`timescale 1ns/1ps
`include "rdc_defines.vh"
module rdc_redist_ctrl #(
    parameter GROUP_DISABLE_SUPPORTED = 1,
    parameter MSG_SUPPORTED = 1,
    parameter MSG_ENABLE_LOCKS = 0,
    parameter CLEAR_ENABLE_ON_ROUTE_OFF = 1,
    parameter PROP_CYCLES = `RDC_PROP_CYCLES
) (
    CORE_CLK,
    RST_B,
    REG_SEL,
    REG_WR,
    REG_ADDR,
    REG_WDATA,
    REG_SECURE,
    REG_RDATA,
    SINGLE_SECURITY_STATE,
    NONSECURE_AFFINITY_ROUTING_EN,
    SECURE_AFFINITY_ROUTING_EN,
    WAKE_ON_NONSECURE_GROUP1,
    PROCESSOR_ASLEEP,
    GRP0_EN,
    GRP1S_EN,
    GRP1NS_EN,
    UPSTREAM_BUSY,
    IRQ_GROUP_SECURE,
    IRQ_ACTIVE,
    IRQ_FWD_EN,
    FWD_G0,
    FWD_G1S,
    FWD_G1NS,
    SELECTABLE_G0,
    SELECTABLE_G1S,
    SELECTABLE_G1NS,
    RETARGET_REQ,
    DEACTIVATE,
    DISABLE_FWD,
    MSG_INTERRUPT_ENABLE,
    PENDING_LOAD_START
);
    // clock and reset
    input wire CORE_CLK;
    input wire RST_B;

    // memory-mapped register port
    input wire REG_SEL;
    input wire REG_WR;
    input wire [15:0] REG_ADDR;
    input wire [31:0] REG_WDATA;
    input wire REG_SECURE;
    output reg [31:0] REG_RDATA;

    // security and routing configuration from the distributor
    input wire SINGLE_SECURITY_STATE;
    input wire NONSECURE_AFFINITY_ROUTING_EN;
    input wire SECURE_AFFINITY_ROUTING_EN;
    input wire WAKE_ON_NONSECURE_GROUP1;

    // processor state and group enables
    input wire PROCESSOR_ASLEEP;
    input wire GRP0_EN;
    input wire GRP1S_EN;
    input wire GRP1NS_EN;
    input wire UPSTREAM_BUSY;

    // banked interrupt state held on the far side
    input wire [31:0] IRQ_GROUP_SECURE;
    input wire [31:0] IRQ_ACTIVE;
    input wire [31:0] IRQ_FWD_EN;
    input wire FWD_G0;
    input wire FWD_G1S;
    input wire FWD_G1NS;

    // eligibility levels and one-cycle requests
    output wire SELECTABLE_G0;
    output wire SELECTABLE_G1S;
    output wire SELECTABLE_G1NS;
    output reg RETARGET_REQ;
    output reg [31:0] DEACTIVATE;
    output reg [31:0] DISABLE_FWD;
    output wire MSG_INTERRUPT_ENABLE;
    output reg PENDING_LOAD_START;

    reg dis_g0_reg;
    reg dis_g1s_reg;
    reg dis_g1ns_reg;
    reg msg_en_reg;
    reg ns_route_d_reg;
    reg [7:0] rwp_cnt_reg;
    reg [7:0] rwp_cnt_next;
    wire wr_ctrl;
    wire wr_cact;
    wire wr_cena;
    wire rd_any;
    wire g0_ok;
    wire g1s_ok;
    wire g1ns_ok;
    wire msg_ok;
    wire [31:0] bit_ok;
    wire dis_change;
    wire en_clear;
    wire chg_g0;
    wire chg_g1s;
    wire chg_g1ns;
    wire retarget_next;
    wire awake;
    wire [31:0] ctrl_word;
    wire [31:0] cact_word;
    wire [31:0] cena_word;
    wire [31:0] deact_next;
    wire [31:0] disfwd_next;
    genvar g;

    // register hit for one offset, used by the write decode only
    function hit;
        input [15:0] addr;
        input [15:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    // per-bit access mask for a given security state
    function [31:0] access_mask;
        input [31:0] grp_sec;
        input sec;
        input single;
        input route_s;
        input route_ns;
        integer i;
        begin
            access_mask = 32'h0;
            for (i = 0; i < 32; i = i + 1) begin
                // routing per the interrupt's own security state
                access_mask[i] = (grp_sec[i] ? route_s : route_ns) &&
                    (single || sec || !grp_sec[i]);
            end
        end
    endfunction

    // address decode
    assign wr_ctrl = REG_SEL && REG_WR && hit(REG_ADDR, `RDC_OFF_CONTROL);
    assign wr_cact = REG_SEL && REG_WR && hit(REG_ADDR, `RDC_OFF_CLEAR_ACTIVE);
    assign wr_cena = REG_SEL && REG_WR && hit(REG_ADDR, `RDC_OFF_CLEAR_ENABLE);
    assign rd_any = REG_SEL && !REG_WR;

    // field access gating
    assign g1s_ok = (GROUP_DISABLE_SUPPORTED != 0) && !SINGLE_SECURITY_STATE && REG_SECURE;
    assign g0_ok = (GROUP_DISABLE_SUPPORTED != 0) && (SINGLE_SECURITY_STATE || REG_SECURE);
    assign g1ns_ok = (GROUP_DISABLE_SUPPORTED != 0);
    assign msg_ok = (MSG_SUPPORTED != 0) && NONSECURE_AFFINITY_ROUTING_EN;
    assign bit_ok = access_mask(IRQ_GROUP_SECURE, REG_SECURE, SINGLE_SECURITY_STATE,
        SECURE_AFFINITY_ROUTING_EN, NONSECURE_AFFINITY_ROUTING_EN);

    // per-group disable-bit changes accepted by the current access
    assign chg_g0 = g0_ok && (REG_WDATA[`RDC_BIT_DIS_G0] != dis_g0_reg);
    assign chg_g1s = g1s_ok && (REG_WDATA[`RDC_BIT_DIS_G1S] != dis_g1s_reg);
    assign chg_g1ns = g1ns_ok && (REG_WDATA[`RDC_BIT_DIS_G1NS] != dis_g1ns_reg);
    assign dis_change = wr_ctrl && (chg_g0 || chg_g1s || chg_g1ns);

    // retarget only if a forwarded group's disable bit changed
    assign retarget_next = wr_ctrl && ((chg_g0 && FWD_G0) || (chg_g1s && FWD_G1S) ||
        (chg_g1ns && FWD_G1NS));
    assign en_clear = wr_ctrl && msg_ok && msg_en_reg && !REG_WDATA[`RDC_BIT_MSG_EN] &&
        (MSG_ENABLE_LOCKS == 0);

    // asleep never selectable here whatever the wake option
    assign awake = !PROCESSOR_ASLEEP;

    // one-of-N eligibility per group
    assign SELECTABLE_G0 = awake && !dis_g0_reg && GRP0_EN;
    assign SELECTABLE_G1S = awake && !dis_g1s_reg && GRP1S_EN;
    assign SELECTABLE_G1NS = awake && !dis_g1ns_reg && GRP1NS_EN &&
        !(PROCESSOR_ASLEEP && WAKE_ON_NONSECURE_GROUP1);
    assign MSG_INTERRUPT_ENABLE = msg_en_reg && NONSECURE_AFFINITY_ROUTING_EN;

    // control word as read; gated fields read zero where the access may not see them
    assign ctrl_word = {
        UPSTREAM_BUSY,
        4'h0,
        dis_g1s_reg && g1s_ok,
        dis_g1ns_reg && g1ns_ok,
        dis_g0_reg && g0_ok,
        20'h0,
        (rwp_cnt_reg != 8'h00),
        2'h0,
        msg_en_reg && msg_ok
    };

    // clear-register read words, state visible only where the access may reach it
    assign cact_word = IRQ_ACTIVE & bit_ok;
    assign cena_word = IRQ_FWD_EN & bit_ok;

    // per-interrupt pulse requests; bits 15:0 software-generated, 31:16 private
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_pulse
            // deactivate only what is active and reachable by this access
            assign deact_next[g] = wr_cact && REG_WDATA[g] && bit_ok[g] &&
                IRQ_ACTIVE[g];
            // disable forwarding only where it is enabled and reachable
            assign disfwd_next[g] = wr_cena && REG_WDATA[g] && bit_ok[g] &&
                IRQ_FWD_EN[g];
        end
    endgenerate

    // propagation counter restarted by every tracked write
    always @* begin
        rwp_cnt_next = rwp_cnt_reg;
        if (dis_change || en_clear || wr_cena) begin
            rwp_cnt_next = PROP_CYCLES[7:0];
        end else if (rwp_cnt_reg != 8'h00) begin
            rwp_cnt_next = rwp_cnt_reg - 8'h01;
        end
    end

    // control fields, strobes and propagation state
    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            dis_g0_reg <= `RDC_CTRL_RESET;
            dis_g1s_reg <= `RDC_CTRL_RESET;
            dis_g1ns_reg <= `RDC_CTRL_RESET;
            msg_en_reg <= `RDC_CTRL_RESET;
            ns_route_d_reg <= 1'b0;
            rwp_cnt_reg <= 8'h00;
            RETARGET_REQ <= 1'b0;
            PENDING_LOAD_START <= 1'b0;
            DEACTIVATE <= 32'h0;
            DISABLE_FWD <= 32'h0;
        end else begin
            ns_route_d_reg <= NONSECURE_AFFINITY_ROUTING_EN;
            rwp_cnt_reg <= rwp_cnt_next;
            PENDING_LOAD_START <= 1'b0;
            if (wr_ctrl) begin
                if (g0_ok) begin
                    dis_g0_reg <= REG_WDATA[`RDC_BIT_DIS_G0];
                end
                if (g1s_ok) begin
                    dis_g1s_reg <= REG_WDATA[`RDC_BIT_DIS_G1S];
                end
                if (g1ns_ok) begin
                    dis_g1ns_reg <= REG_WDATA[`RDC_BIT_DIS_G1NS];
                end
                if (msg_ok && REG_WDATA[`RDC_BIT_MSG_EN] && !msg_en_reg) begin
                    msg_en_reg <= 1'b1;
                    PENDING_LOAD_START <= 1'b1;
                end else if (en_clear) begin
                    msg_en_reg <= 1'b0;
                end
            end
            if (ns_route_d_reg && !NONSECURE_AFFINITY_ROUTING_EN &&
                (CLEAR_ENABLE_ON_ROUTE_OFF != 0)) begin
                msg_en_reg <= 1'b0;
            end
            RETARGET_REQ <= retarget_next;
            DEACTIVATE <= deact_next;
            DISABLE_FWD <= disfwd_next;
        end
    end

    // read data, registered; unmapped offsets read zero
    always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 32'h0;
        end else if (rd_any) begin
            REG_RDATA <= 32'h0;
            case (REG_ADDR)
                `RDC_OFF_CONTROL: begin
                    REG_RDATA <= ctrl_word;
                end
                `RDC_OFF_CLEAR_ACTIVE: begin
                    REG_RDATA <= cact_word;
                end
                `RDC_OFF_CLEAR_ENABLE: begin
                    REG_RDATA <= cena_word;
                end
                default: begin
                    REG_RDATA <= 32'h0;
                end
            endcase
        end
    end
endmodule
